// File: hw/slave_port_pkg.sv
// Shared constants and types of the mailbox slave port.
package slave_port_pkg;

    // Mailbox space and pointer layout.
    localparam int MAILBOX_COUNT = 32;
    localparam int PTR_W = 6;
    localparam logic [5:0] PTR_RESET = 6'h00;
    localparam logic [5:0] MAILBOX_END = 6'h20;
    localparam logic [5:0] SEM_BASE = 6'h20;
    localparam int SEM_COUNT = 2;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Serial framing.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

    // Highest serial rate and the clock cycles that one bit spans at it.
    localparam int CLOCK_HZ = 10_000_000;
    localparam int I2C_MAX_RATE_BPS = 2_000_000;
    localparam int MIN_BIT_CYCLES = (CLOCK_HZ + I2C_MAX_RATE_BPS - 1) / I2C_MAX_RATE_BPS;

    // Serial slave states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_RX_DATA = 3'b010,
        ST_RX_ACK = 3'b110,
        ST_TX_DATA = 3'b111,
        ST_TX_ACK = 3'b101
    } i2c_state_e;

endpackage : slave_port_pkg

// File: hw/bit_sync.sv
// Two flip-flop synchroniser for a group of independent levels.
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain.
    output logic [WIDTH-1:0] sync_out // Levels safe to read.
);

    ////////////////////////////////////////////////////////////////////////
    // One plain two-stage chain per bit; the first stage feeds only the second.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_reg;
        logic meta_next;
        logic stable_reg;
        logic stable_next;

        // Next values of the chain.
        always_comb begin
            meta_next = async_in[i];
            stable_next = meta_reg;
        end

        // Register the chain.
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                meta_reg <= 1'b0;
                stable_reg <= 1'b0;
            end else begin
                meta_reg <= meta_next;
                stable_reg <= stable_next;
            end
        end

        assign sync_out[i] = stable_reg;
    end

endmodule : bit_sync

// File: hw/mailbox_bank.sv
// Mailbox byte array with host write tracking.
`timescale 1ns/1ps
module mailbox_bank
    import slave_port_pkg::*;
#(
    parameter int COUNT = slave_port_pkg::MAILBOX_COUNT,
    parameter int ADDR_W = $clog2(COUNT)
) (
    input wire logic clock, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic cpu_we, // CPU byte write strobe.
    input wire logic [ADDR_W-1:0] cpu_addr, // CPU mailbox index.
    input wire logic [7:0] cpu_wdata, // CPU write byte.
    output logic [7:0] cpu_rdata, // CPU read byte, one cycle after the address.
    input wire logic host_we, // Serial host byte write strobe.
    input wire logic [ADDR_W-1:0] host_addr, // Serial host mailbox index.
    input wire logic [7:0] host_wdata, // Serial host write byte.
    input wire logic [ADDR_W-3:0] row_sel, // Four-byte row to present.
    output logic [31:0] row_word, // Selected row, lowest address in the top byte.
    input wire logic [COUNT-1:0] written_clear, // CPU clears host write flags.
    output logic [COUNT-1:0] written_flags // Mailboxes written by the host.
);

    logic [7:0] mem_reg [COUNT];
    logic [COUNT-1:0] written_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////
    // Each entry takes CPU and host writes; the host write lands last.
    for (genvar i = 0; i < COUNT; i++) begin : g_entry
        logic [7:0] mem_next;
        logic written_next;

        // Next value of the byte and of its written flag.
        always_comb begin
            mem_next = mem_reg[i];
            written_next = written_reg[i];
            if (cpu_we && cpu_addr == ADDR_W'(i)) begin // [RULE10]
                mem_next = cpu_wdata;
            end
            if (written_clear[i]) begin
                written_next = 1'b0;
            end
            if (host_we && host_addr == ADDR_W'(i)) begin // [RULE10]
                mem_next = host_wdata;
                written_next = 1'b1; // [RULE13]
            end
        end

        // Register the entry.
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                mem_reg[i] <= BYTE_RESET;
                written_reg[i] <= 1'b0;
            end else begin
                mem_reg[i] <= mem_next;
                written_reg[i] <= written_next;
            end
        end
    end

    // CPU read port is registered.
    always_comb begin
        rdata_next = mem_reg[cpu_addr];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= BYTE_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Big-endian row view for the serial read buffer.
    assign row_word = {mem_reg[{row_sel, 2'b00}], mem_reg[{row_sel, 2'b01}],
                       mem_reg[{row_sel, 2'b10}], mem_reg[{row_sel, 2'b11}]}; // [RULE19]
    assign cpu_rdata = rdata_reg;
    assign written_flags = written_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the array.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_host_write_flag: assert property (host_we |=> written_reg[$past(host_addr)]) // [RULE13]
        else $error("host write did not set its written flag");
    a_cpu_write_lands: assert property ((cpu_we && !(host_we && host_addr == cpu_addr))
        |=> mem_reg[$past(cpu_addr)] == $past(cpu_wdata)) // [RULE10]
        else $error("cpu write did not reach the mailbox");

endmodule : mailbox_bank

// File: hw/slave_port_i2c_mailbox.sv
// Serial mailbox slave port: boot mode pick, I2C slave, read buffer, semaphores.
// How it works
// RULE1: select pin low at boot chooses SPI.
// RULE2: select pin high at boot chooses I2C.
// RULE3: port logic runs from serial clock edges.
// RULE4: serve transfers except in deep sleep.
// RULE5: deep sleep address match or deselect wakes.
// RULE6: chip reset silences the port completely.
// RULE7: host holds select pin at mode level.
// RULE8: SPI host drives select low before reset.
// RULE9: SPI host keeps select low 1 ms.
// RULE10: 32 byte mailboxes, CPU and host access.
// RULE11: 32-bit read buffer keeps reads consistent.
// RULE12: two semaphores arbitrate shared mailbox data.
// RULE13: flags record mailboxes the host wrote.
// RULE14: pointer steps per byte, 31 wraps 0.
// RULE15: seven-bit address only; general call ignored.
// RULE16: serial clock up to 2 Mbps.
// RULE17: clock and data sampled without filtering.
// RULE18: read latches aligned row; group reads reuse it.
// RULE19: big-endian rows, lowest address most significant.
// RULE20: first written byte loads the pointer.
// RULE21: crossing signals synchronised before use.
`timescale 1ns/1ps
module slave_port_i2c_mailbox
    import slave_port_pkg::*;
(
    input wire logic clock, // System clock, 10 MHz.
    input wire logic reset_n, // Chip reset, asynchronous, active low.
    input wire logic boot_done, // One-cycle pulse at the end of boot.
    input wire logic boot_mode_select_pin, // Shared mode pin, also the SPI select.
    input wire logic scl_in, // Serial clock pin.
    input wire logic sda_in, // Serial data pin level.
    output logic sda_out, // Serial data output, always low when enabled.
    output logic sda_oe, // Serial data output enable, high pulls low.
    input wire logic [6:0] slave_address, // Configured seven-bit address.
    input wire logic wake_enable, // Allows wake-up from deep sleep.
    input wire logic deep_sleep_state, // Chip is in deep sleep.
    output logic wake_request, // One-cycle wake-up pulse.
    output logic spi_mode, // SPI mode picked at boot.
    output logic i2c_mode, // I2C mode picked at boot.
    input wire logic cpu_we, // CPU mailbox write strobe.
    input wire logic [4:0] cpu_addr, // CPU mailbox index.
    input wire logic [7:0] cpu_wdata, // CPU write byte.
    output logic [7:0] cpu_rdata, // CPU read byte.
    input wire logic [31:0] written_clear, // Clears host write flags.
    output logic [31:0] written_flags, // Host write flags.
    input wire logic [1:0] cpu_sem_take, // CPU semaphore take pulses.
    input wire logic [1:0] cpu_sem_release, // CPU semaphore release pulses.
    output logic [1:0] sem_taken, // Semaphore busy.
    output logic [1:0] sem_by_host // Semaphore last taken by the host.
);

    logic pin_s;
    logic scl_s;
    logic sda_s;
    logic pin_prev_reg, scl_prev_reg, sda_prev_reg;
    logic spi_reg, spi_next, i2c_reg, i2c_next;
    i2c_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next, tx_reg, tx_next;
    logic [PTR_W-1:0] ptr_reg, ptr_next, ptr_step;
    logic rw_reg, rw_next, first_reg, first_next;
    logic drive_reg, drive_next, mack_reg, mack_next;
    logic bvalid_reg, bvalid_next;
    logic [2:0] brow_reg, brow_next;
    logic [31:0] bword_reg, bword_next, row_word, word;
    logic wake_reg, wake_next;
    logic [1:0] semt_reg, semt_next, semh_reg, semh_next;
    logic start, stop, scl_rise, scl_fall, addr_match, row_hit;
    logic tx_load, host_we, sem_write;
    logic [7:0] read_byte, mb_byte;

    ////////////////////////////////////////////////////////////////////////
    // Pins cross into the clock domain through plain two-stage chains.
    bit_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in({boot_mode_select_pin, scl_in, sda_in}),
        .sync_out({pin_s, scl_s, sda_s}) // [RULE21] [RULE17]
    );

    // Edge and condition detection on the synchronised lines, no filtering.
    assign scl_rise = scl_s && !scl_prev_reg; // [RULE3] [RULE17] [RULE16]
    assign scl_fall = !scl_s && scl_prev_reg; // [RULE3]
    assign start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
    assign addr_match = shift_reg[7:1] == slave_address && shift_reg[7:1] != GENERAL_CALL_ADDR; // [RULE15]

    ////////////////////////////////////////////////////////////////////////
    // Mailbox array shared by CPU and host.
    mailbox_bank u_bank (
        .clock(clock),
        .reset_n(reset_n),
        .cpu_we(cpu_we),
        .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata),
        .host_we(host_we),
        .host_addr(ptr_reg[4:0]),
        .host_wdata(shift_reg),
        .row_sel(ptr_reg[4:2]),
        .row_word(row_word),
        .written_clear(written_clear),
        .written_flags(written_flags)
    );

    // Read path: a latched row serves the rest of its group.
    always_comb begin
        row_hit = bvalid_reg && brow_reg == ptr_reg[4:2];
        word = row_hit ? bword_reg : row_word; // [RULE18] [RULE11]
        unique case (ptr_reg[1:0])
            2'b00: mb_byte = word[31:24]; // [RULE19]
            2'b01: mb_byte = word[23:16];
            2'b10: mb_byte = word[15:8];
            2'b11: mb_byte = word[7:0];
        endcase
        if (ptr_reg < MAILBOX_END) begin
            read_byte = mb_byte;
        end else if (ptr_reg == SEM_BASE || ptr_reg == SEM_BASE + 6'h01) begin
            read_byte = {6'h00, semh_reg[ptr_reg[0]], semt_reg[ptr_reg[0]]};
        end else begin
            read_byte = BYTE_RESET;
        end
        // Mailbox addresses step and wrap; semaphore addresses hold.
        ptr_step = (ptr_reg < MAILBOX_END) ? {1'b0, ptr_reg[4:0] + 5'h01} : ptr_reg; // [RULE14]
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the mode pick and the serial slave.
    always_comb begin
        spi_next = spi_reg;
        i2c_next = i2c_reg;
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        drive_next = drive_reg;
        mack_next = mack_reg;
        bvalid_next = bvalid_reg;
        brow_next = brow_reg;
        bword_next = bword_reg;
        wake_next = 1'b0;
        tx_load = 1'b0;
        host_we = 1'b0;
        sem_write = 1'b0;
        if (boot_done) begin
            spi_next = !pin_s; // [RULE1]
            i2c_next = pin_s; // [RULE2]
        end
        // In SPI mode only the deselect wake-up is served here.
        if (spi_reg && deep_sleep_state && wake_enable && pin_s && !pin_prev_reg) begin
            wake_next = 1'b1; // [RULE5]
        end
        if (!i2c_reg) begin
            state_next = ST_IDLE;
            drive_next = 1'b0;
        end else if (start) begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            drive_next = 1'b0;
            bvalid_next = 1'b0;
        end else if (stop) begin
            state_next = ST_IDLE;
            drive_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                end
                ST_ADDR, ST_RX_DATA: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == BYTE_BITS) begin
                        cnt_next = 4'h0;
                        if (state_reg == ST_RX_DATA) begin
                            state_next = ST_RX_ACK;
                            drive_next = 1'b1;
                            first_next = 1'b0;
                            if (first_reg) begin
                                ptr_next = shift_reg[PTR_W-1:0]; // [RULE20]
                                bvalid_next = 1'b0;
                            end else begin
                                host_we = ptr_reg < MAILBOX_END; // [RULE10] [RULE20]
                                sem_write = ptr_reg[PTR_W-1:1] == SEM_BASE[PTR_W-1:1];
                                ptr_next = ptr_step; // [RULE14]
                            end
                        end else if (addr_match && !deep_sleep_state) begin
                            state_next = ST_ADDR_ACK; // [RULE4]
                            drive_next = 1'b1;
                            rw_next = shift_reg[0];
                        end else begin
                            state_next = ST_IDLE; // [RULE15]
                            wake_next = addr_match && wake_enable; // [RULE5]
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_next = rw_reg ? ST_TX_DATA : ST_RX_DATA;
                        drive_next = 1'b0;
                        first_next = 1'b1;
                        tx_load = rw_reg;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        state_next = ST_RX_DATA;
                        drive_next = 1'b0;
                    end
                end
                ST_TX_DATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == BYTE_BITS) begin
                        state_next = ST_TX_ACK;
                        drive_next = 1'b0;
                        cnt_next = 4'h0;
                        ptr_next = ptr_step; // [RULE14]
                    end else if (scl_fall) begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        drive_next = !tx_reg[6];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        mack_next = !sda_s;
                    end else if (scl_fall) begin
                        state_next = mack_reg ? ST_TX_DATA : ST_IDLE;
                        tx_load = mack_reg;
                    end
                end
            endcase
        end
        // Present a new byte, latching its row when it is a mailbox.
        if (tx_load) begin
            tx_next = read_byte;
            drive_next = !read_byte[7];
            if (ptr_reg < MAILBOX_END) begin
                bvalid_next = 1'b1; // [RULE18]
                brow_next = ptr_reg[4:2];
                bword_next = word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Semaphores: CPU takes first when both ask for a free one.
    always_comb begin
        semt_next = semt_reg;
        semh_next = semh_reg;
        for (int i = 0; i < SEM_COUNT; i++) begin
            if (!semt_reg[i] && cpu_sem_take[i]) begin
                semt_next[i] = 1'b1; // [RULE12]
                semh_next[i] = 1'b0;
            end else if (!semt_reg[i] && sem_write && ptr_reg[0] == i[0] && shift_reg[0]) begin
                semt_next[i] = 1'b1; // [RULE12]
                semh_next[i] = 1'b1;
            end else if (semt_reg[i] && !semh_reg[i] && cpu_sem_release[i]) begin
                semt_next[i] = 1'b0;
            end else if (semt_reg[i] && semh_reg[i] && sem_write && ptr_reg[0] == i[0] && !shift_reg[0]) begin
                semt_next[i] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register all state; chip reset clears everything but scl_prev_reg and sda_prev_reg, which reset high, and releases the line.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_prev_reg <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            spi_reg <= 1'b0;
            i2c_reg <= 1'b0;
            state_reg <= ST_IDLE; // [RULE6]
            cnt_reg <= 4'h0;
            shift_reg <= BYTE_RESET;
            tx_reg <= BYTE_RESET;
            ptr_reg <= PTR_RESET;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            drive_reg <= 1'b0; // [RULE6]
            mack_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            brow_reg <= 3'h0;
            bword_reg <= WORD_RESET;
            wake_reg <= 1'b0;
            semt_reg <= 2'h0;
            semh_reg <= 2'h0;
        end else begin
            pin_prev_reg <= pin_s;
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            spi_reg <= spi_next;
            i2c_reg <= i2c_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            drive_reg <= drive_next;
            mack_reg <= mack_next;
            bvalid_reg <= bvalid_next;
            brow_reg <= brow_next;
            bword_reg <= bword_next;
            wake_reg <= wake_next;
            semt_reg <= semt_next;
            semh_reg <= semh_next;
        end
    end

    // Outputs straight from flip-flops, except sda_out, which is tied low.
    assign sda_out = 1'b0;
    assign sda_oe = drive_reg;
    assign wake_request = wake_reg;
    assign spi_mode = spi_reg;
    assign i2c_mode = i2c_reg;
    assign sem_taken = semt_reg;
    assign sem_by_host = semh_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks and coverage of the main scenarios.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_boot_spi_pick: assert property (boot_done && !pin_s |=> spi_mode && !i2c_mode) // [RULE1]
        else $error("low select pin at boot did not pick SPI");
    a_boot_i2c_pick: assert property (boot_done && pin_s |=> i2c_mode && !spi_mode) // [RULE2]
        else $error("high select pin at boot did not pick I2C");
    a_sleep_no_ack: assert property (state_reg == ST_ADDR && deep_sleep_state && scl_fall
        && cnt_reg == BYTE_BITS && !start && !stop |=> !sda_oe && state_reg == ST_IDLE) // [RULE4]
        else $error("address acknowledged in deep sleep");
    a_wake_on_match: assert property (i2c_mode && state_reg == ST_ADDR && deep_sleep_state
        && wake_enable && addr_match && scl_fall && cnt_reg == BYTE_BITS && !start && !stop
        |=> wake_request ##1 !wake_request) // [RULE5]
        else $error("address match in deep sleep gave no wake pulse");
    a_quiet_after_reset: assert property ($rose(reset_n) |-> !sda_oe && state_reg == ST_IDLE
        && !wake_request) // [RULE6]
        else $error("port active straight after reset");
    a_ptr_wrap: assert property (ptr_reg == 6'h1f && state_reg == ST_TX_DATA && scl_fall
        && cnt_reg == BYTE_BITS && !start && !stop |=> ptr_reg == PTR_RESET) // [RULE14]
        else $error("pointer did not wrap from last mailbox");
    a_gencall_ignored: assert property (state_reg == ST_ADDR && shift_reg[7:1] == GENERAL_CALL_ADDR
        && scl_fall && cnt_reg == BYTE_BITS |=> !sda_oe) // [RULE15]
        else $error("general call acknowledged");
    a_buffer_hold: assert property (bvalid_reg && !start && !tx_load
        |=> $stable(bword_reg) && $stable(brow_reg)) // [RULE18] [RULE11]
        else $error("read buffer changed without a new row load");
    a_sem_host_owned: assert property (semt_reg[0] && semh_reg[0] && cpu_sem_release[0]
        && !sem_write |=> semt_reg[0] && semh_reg[0]) // [RULE12]
        else $error("cpu released a semaphore held by the host");

    c_host_write: cover property (host_we);
    c_host_read_run: cover property (tx_load && row_hit);
    c_wake_pulse: cover property (wake_request);
    c_host_sem_take: cover property (sem_write ##1 semh_reg != 2'h0);

endmodule : slave_port_i2c_mailbox

// File: bench/i2c_host.sv
// Bus master model that drives the serial clock and data of the port.
`timescale 1ns/1ps
module i2c_host (
    output logic scl = 1'b1, // Serial clock, high when idle.
    output logic sda_low = 1'b0, // High while the host pulls data low.
    input wire logic sda // Resolved data wire.
);
    // Start, also used as repeated start: data falls while the clock is high.
    task automatic start();
        #400 sda_low = 1'b0;
        #200 scl = 1'b1;
        #400 sda_low = 1'b1;
        #400 scl = 1'b0;
    endtask : start
    // Stop: data rises while the clock is high.
    task automatic stop();
        #100 sda_low = 1'b1;
        #200 scl = 1'b1;
        #400 sda_low = 1'b0;
    endtask : stop
    // Eight bits MSB first plus acknowledge, 800 ns a bit; released bits read the wire.
    task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
        logic [8:0] sh;
        sh = {tx, ack_tx};
        for (int i = 8; i >= 0; i--) begin
            #100 sda_low = ~sh[i];
            #300 scl = 1'b1;
            #200 sh[i] = sda;
            #200 scl = 1'b0;
        end
        rx = sh[8:1];
        ack_rx = sh[0];
    endtask : byte_io
endmodule : i2c_host

// File: bench/slave_port_i2c_mailbox_tb.sv
// Self-checking bench of the serial mailbox slave port.
`timescale 1ns/1ps
module slave_port_i2c_mailbox_tb;
    logic clock = 0, reset_n = 0, boot_done = 0, pin = 0, we = 0, sleep = 0, scl, sda_low, ack, sda_oe, wake, spi, i2c;
    logic [4:0] addr = 0;
    logic [7:0] wd = 0, rx, rd;
    logic [1:0] take = 0, rel = 0, taken, hsem;
    logic [31:0] flags, clr = 0;
    int failures = 0, checks_done = 0, wakes = 0;
    logic [4:0] row_ptr [4] = '{5'h00, 5'h04, 5'h1f, 5'h11};
    logic [7:0] row_data [4] = '{8'h5a, 8'ha5, 8'hff, 8'h01};
    wire sda = ~(sda_low | sda_oe);
    i2c_host host (.scl(scl), .sda_low(sda_low), .sda(sda));
    slave_port_i2c_mailbox dut (.clock(clock), .reset_n(reset_n), .boot_done(boot_done),
        .boot_mode_select_pin(pin), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .slave_address(7'h2a), .wake_enable(1'b1), .deep_sleep_state(sleep), .wake_request(wake),
        .spi_mode(spi), .i2c_mode(i2c), .cpu_we(we), .cpu_addr(addr), .cpu_wdata(wd), .cpu_rdata(rd),
        .written_clear(clr), .written_flags(flags), .cpu_sem_take(take), .cpu_sem_release(rel),
        .sem_taken(taken), .sem_by_host(hsem));
    // Clock, and a count of wake pulses.
    initial forever #50 clock = ~clock;
    always @(posedge clock) if (wake) wakes++;
    // Shared checks, bus helpers and the closing task.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [7:0] b, input logic exp);
        host.byte_io(b, 1'b1, rx, ack);
        chk(ack, exp);
    endtask : put
    task automatic get(input logic [7:0] exp, input logic last);
        host.byte_io(8'hff, last, rx, ack);
        chk(rx, exp);
    endtask : get
    task automatic cpu(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge clock) #10 {addr, we, wd} = {a, w, d};
        @(posedge clock) #10 we = 0;
    endtask : cpu
    task automatic boot(input logic level);
        @(posedge clock) #10 {reset_n, pin} = {1'b0, level};
        @(posedge clock) #10 reset_n = 1;
        chk({spi, i2c, sda_oe, flags}, 0);
        repeat (4) @(posedge clock);
        #10 boot_done = 1;
        @(posedge clock) #10 boot_done = 0;
    endtask : boot
    task automatic wrap_up();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    // Main sequence: boot modes, mailbox rows, then the awkward cases.
    initial begin
        repeat (7) @(posedge clock);
        boot(1'b0);
        chk({spi, i2c}, 2'b10);
        host.start();
        put(8'h54, 1'b1);
        host.stop();
        repeat (10000) @(posedge clock);
        @(posedge clock) #10 {sleep, pin} = 2'b11;
        repeat (6) @(posedge clock);
        chk(wakes, 1);
        $display("spi boot test done");
        #10 sleep = 0;
        boot(1'b1);
        chk({spi, i2c}, 2'b01);
        foreach (row_ptr[i]) begin
            host.start();
            put(8'h54, 1'b0);
            put(row_ptr[i], 1'b0);
            put(row_data[i], 1'b0);
            put(row_data[i] ^ 8'hff, 1'b0);
            host.stop();
            cpu(row_ptr[i], 1'b0, 8'h00);
            chk(rd, row_data[i]);
            chk(flags[row_ptr[i]], 1'b1);
            cpu(row_ptr[i] + 5'h01, 1'b0, 8'h00);
            chk(rd, row_data[i] ^ 8'hff);
        end
        @(posedge clock) #10 clr = flags;
        @(posedge clock) #10 clr = 0;
        chk(flags, 0);
        $display("row test done");
        for (int i = 0; i < 4; i++) cpu(5'h08 + i[4:0], 1'b1, 8'h81 + i[7:0]);
        host.start();
        put(8'h54, 1'b0);
        put(8'h08, 1'b0);
        host.start();
        put(8'h55, 1'b0);
        get(8'h81, 1'b0);
        cpu(5'h09, 1'b1, 8'hee);
        get(8'h82, 1'b0);
        get(8'h83, 1'b0);
        get(8'h84, 1'b1);
        host.start();
        put(8'h56, 1'b1);
        host.start();
        put(8'h00, 1'b1);
        host.stop();
        @(posedge clock) #10 take = 2'b01;
        @(posedge clock) #10 take = 2'b00;
        chk(taken, 2'b01);
        host.start();
        put(8'h54, 1'b0);
        put(8'h21, 1'b0);
        put(8'h01, 1'b0);
        host.stop();
        chk({hsem, taken}, 4'b1011);
        @(posedge clock) #10 rel = 2'b11;
        @(posedge clock) #10 rel = 2'b00;
        chk({hsem, taken}, 4'b1010);
        sleep = 1;
        host.start();
        put(8'h54, 1'b1);
        host.stop();
        chk(wakes, 2);
        $display("awkward cases done");
        wrap_up();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #3000000;
        failures++;
        wrap_up();
    end
endmodule : slave_port_i2c_mailbox_tb
